// ---- hw/bay_controller.sv ----
// bay controller register bank with ahb-lite slave, bay pin logic and interrupt
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps

module bay_controller #(
    parameter logic [15:0] MAKER_CODE    = 16'h1a2b, // arbitrary value
    parameter logic [7:0]  REVISION      = 8'h01,    // arbitrary value
    parameter logic [15:0] SUBMAKER_CODE = 16'h3c4d, // arbitrary value
    parameter logic [15:0] SUB_CODE      = 16'h0001, // arbitrary value
    parameter logic [3:0]  DEB_TIME      = 4'h1,
    parameter logic        SECLOCK_FIT   = 1'b1,
    parameter logic [2:0]  FORM_FACTOR   = 3'h0,
    parameter logic        IL_POL        = 1'b1,
    parameter logic        PWR_POL       = 1'b1,
    parameter logic        REM_POL       = 1'b0,
    parameter logic        LOCK_POL      = 1'b1
) (
    input  wire logic                              i_clk,
    input  wire logic                              i_rst_n,
    input  wire logic                              i_ce,
    input  wire logic                              i_hsel,
    input  wire logic [31:0]                       i_haddr,
    input  wire logic [1:0]                        i_htrans,
    input  wire logic                              i_hwrite,
    input  wire logic [2:0]                        i_hsize,
    input  wire logic [31:0]                       i_hwdata,
    input  wire logic                              i_hready,
    output logic [31:0]                            o_hrdata,
    output logic                                   o_hreadyout,
    output logic                                   o_hresp,
    input  wire logic [bay_ctrl_pkg::NUM_BAYS-1:0] i_removal_button_in,
    input  wire logic [bay_ctrl_pkg::NUM_BAYS-1:0] i_physical_lock_sense,
    output logic [bay_ctrl_pkg::NUM_BAYS-1:0]      o_interlock,
    output logic [bay_ctrl_pkg::NUM_BAYS-1:0]      o_bay_power_switch_out,
    output logic                                   o_irq
);
    localparam int NB = bay_ctrl_pkg::NUM_BAYS;

    bay_ctrl_pkg::state_t st_reg;
    bay_ctrl_pkg::state_t st_next;
    logic                 addr_take;
    logic [NB-1:0]        rem_act;
    logic [NB-1:0]        lock_act;
    logic [NB-1:0]        rem_event;
    logic [NB-1:0]        lock_event;
    logic [2*NB-1:0]      irq_set;
    logic [2*NB-1:0]      irq_clr;

    // per-bay register decode, shared by the read and write paths
    function automatic bay_ctrl_pkg::bay_dec_t bay_decode(input logic [9:0] idx);
        bay_ctrl_pkg::bay_dec_t d;
        logic [9:0]             rel;
        d   = '0;
        rel = idx - bay_ctrl_pkg::IDX_BAY_STAT;
        if (idx >= bay_ctrl_pkg::IDX_BAY_STAT && (rel[2:0] == 3'h0 || rel[2:0] == 3'h4)
            && 32'(rel[9:3]) < NB) begin
            d.hit     = 1'b1;
            d.is_ctrl = rel[2];
            d.bay     = rel[3:3];
        end
        return d;
    endfunction

    // read mux; anything not decoded returns zero
    function automatic logic [31:0] read_word(input logic [9:0] idx, input bay_ctrl_pkg::state_t s,
                                              input logic [NB-1:0] rem_l, input logic [NB-1:0] lock_l);
        logic [31:0]            w;
        bay_ctrl_pkg::bay_dec_t d;
        w = bay_ctrl_pkg::RESET_WORD;
        d = bay_decode(idx);
        if (idx == bay_ctrl_pkg::IDX_MAKER) begin
            w[15:0] = MAKER_CODE;
        end else if (idx == bay_ctrl_pkg::IDX_REV) begin
            w[7:0] = REVISION;
        end else if (idx == bay_ctrl_pkg::IDX_SUBMAKER) begin
            w[15:0] = SUBMAKER_CODE;
        end else if (idx == bay_ctrl_pkg::IDX_SUBCODE) begin
            w[15:0] = SUB_CODE;
        end else if (idx == bay_ctrl_pkg::IDX_CAP) begin
            w[bay_ctrl_pkg::CAP_BAYCNT_LSB +: 4] = 4'(NB);
            w[bay_ctrl_pkg::CAP_SECLOCK]         = SECLOCK_FIT;
            w[bay_ctrl_pkg::CAP_DEB_LSB +: 4]    = DEB_TIME;
        end else if (d.hit && !d.is_ctrl) begin
            w[bay_ctrl_pkg::STS_REMOVAL]      = rem_l[d.bay];
            w[bay_ctrl_pkg::STS_LOCK]         = SECLOCK_FIT & lock_l[d.bay];
            w[bay_ctrl_pkg::STS_FF_LSB +: 3]  = FORM_FACTOR;
        end else if (d.hit) begin
            w[bay_ctrl_pkg::CTL_INTERLOCK] = s.il_ctrl[d.bay];
            w[bay_ctrl_pkg::CTL_POWER]     = s.pwr_ctrl[d.bay];
            w[bay_ctrl_pkg::CTL_PULSE]     = s.pulse_mode[d.bay];
        end else if (idx == bay_ctrl_pkg::IDX_IRQ_STS) begin
            w[2*NB-1:0] = s.irq_sts;
        end else if (idx == bay_ctrl_pkg::IDX_IRQ_EN) begin
            w[2*NB-1:0] = s.irq_en;
        end
        return w;
    endfunction

    // pins after the second synchroniser stage, normalised to active high
    assign rem_act    = st_reg.rem_s2 ^ {NB{~REM_POL}};
    assign lock_act   = st_reg.lock_s2 ^ {NB{~LOCK_POL}};
    assign rem_event  = rem_act & ~st_reg.rem_prev;
    assign lock_event = lock_act ^ st_reg.lock_prev;
    assign irq_set    = {lock_event, rem_event};

    // bus handshake; reads take one wait state so read data comes from a flop
    assign addr_take   = i_hsel & i_htrans[1] & i_hready & i_ce;
    assign o_hreadyout = i_ce & (st_reg.ph != bay_ctrl_pkg::PH_RWAIT);
    assign o_hresp     = 1'b0;
    assign o_hrdata    = st_reg.rdata;
    assign irq_clr     = (st_reg.ph == bay_ctrl_pkg::PH_WRITE && st_reg.ph_idx == bay_ctrl_pkg::IDX_IRQ_CLR)
                         ? i_hwdata[2*NB-1:0] : '0;
    assign o_interlock            = st_reg.il_out;
    assign o_bay_power_switch_out = st_reg.pwr_out;
    assign o_irq                  = st_reg.irq;

    // next-state logic for the whole block
    always_comb begin
        bay_ctrl_pkg::bay_dec_t wd;
        logic [NB-1:0]          il_level;
        wd       = bay_decode(st_reg.ph_idx);
        il_level = '0;
        st_next  = st_reg;

        // synchronisers: first stage feeds only the second
        st_next.rem_s1    = i_removal_button_in;
        st_next.rem_s2    = st_reg.rem_s1;
        st_next.lock_s1   = i_physical_lock_sense;
        st_next.lock_s2   = st_reg.lock_s1;
        st_next.rem_prev  = rem_act;
        st_next.lock_prev = lock_act;

        // bus phase tracking
        case (st_reg.ph)
            bay_ctrl_pkg::PH_RWAIT: begin
                st_next.rdata = read_word(st_reg.ph_idx, st_reg, rem_act, lock_act);
                st_next.ph    = bay_ctrl_pkg::PH_RDONE;
            end
            default: begin
                st_next.ph = bay_ctrl_pkg::PH_IDLE;
                if (addr_take) begin
                    st_next.ph_idx = i_haddr[11:2];
                    st_next.ph     = i_hwrite ? bay_ctrl_pkg::PH_WRITE : bay_ctrl_pkg::PH_RWAIT;
                end
            end
        endcase

        // register writes; identity and capability words have no write path
        if (st_reg.ph == bay_ctrl_pkg::PH_WRITE) begin
            if (wd.hit && wd.is_ctrl) begin
                st_next.il_ctrl[wd.bay]    = i_hwdata[bay_ctrl_pkg::CTL_INTERLOCK];
                st_next.pwr_ctrl[wd.bay]   = i_hwdata[bay_ctrl_pkg::CTL_POWER];
                st_next.pulse_mode[wd.bay] = i_hwdata[bay_ctrl_pkg::CTL_PULSE];
            end else if (st_reg.ph_idx == bay_ctrl_pkg::IDX_IRQ_EN) begin
                st_next.irq_en = i_hwdata[2*NB-1:0];
            end
        end

        // interrupt status: a new event wins over a clear in the same cycle
        st_next.irq_sts = (st_reg.irq_sts & ~irq_clr) | irq_set;
        st_next.irq     = |(st_reg.irq_sts & st_reg.irq_en);

        // per-bay pin drivers
        for (int k = 0; k < NB; k++) begin
            if (st_reg.il_ctrl[k] && !st_next.il_ctrl[k]) begin
                st_next.pulse_cnt[k] = bay_ctrl_pkg::PULSE_CYC;
            end else if (st_reg.pulse_cnt[k] != 9'h000) begin
                st_next.pulse_cnt[k] = st_reg.pulse_cnt[k] - 9'h001;
            end
            il_level[k]        = st_reg.pulse_mode[k] ? (st_reg.pulse_cnt[k] != 9'h000) : st_reg.il_ctrl[k];
            st_next.il_out[k]  = il_level[k] ^ ~IL_POL;
            st_next.pwr_out[k] = st_reg.pwr_ctrl[k] ^ ~PWR_POL;
        end
    end

    // single state register, frozen while the clock enable is low
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg         <= '0;
            st_reg.ph      <= bay_ctrl_pkg::PH_IDLE;
            // synchronisers start at the idle pin level so no false event follows reset
            st_reg.rem_s1  <= {NB{~REM_POL}};
            st_reg.rem_s2  <= {NB{~REM_POL}};
            st_reg.lock_s1 <= {NB{~LOCK_POL}};
            st_reg.lock_s2 <= {NB{~LOCK_POL}};
            st_reg.il_out  <= {NB{~IL_POL}};
            st_reg.pwr_out <= {NB{~PWR_POL}};
        end else if (i_ce) begin
            st_reg <= st_next;
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    sequence rd_addr_s;
        addr_take && !i_hwrite;
    endsequence
    sequence ctl_fall_pulse_s(int k);
        i_ce && st_reg.pulse_mode[k] && st_reg.il_ctrl[k] && !st_next.il_ctrl[k];
    endsequence

    chk_power_follow: assert property (i_ce |=> o_bay_power_switch_out == ($past(st_reg.pwr_ctrl) ^ {NB{~PWR_POL}}))
        else $error("power output does not follow its control bit");
    chk_interlock_level: assert property (i_ce && !st_reg.pulse_mode[0] |=> o_interlock[0] == ($past(st_reg.il_ctrl[0]) ^ ~IL_POL))
        else $error("interlock output does not follow its control bit");
    chk_interlock_pulse_load: assert property (ctl_fall_pulse_s(0) |=> st_reg.pulse_cnt[0] == bay_ctrl_pkg::PULSE_CYC)
        else $error("interlock pulse not started on control fall");
    chk_interlock_pulse_out: assert property (i_ce && st_reg.pulse_mode[0] && st_reg.pulse_cnt[0] != 9'h000 |=> o_interlock[0] == IL_POL)
        else $error("interlock not active during pulse");
    chk_read_wait: assert property (rd_addr_s |=> !o_hreadyout ##1 (o_hreadyout || !i_ce))
        else $error("read does not complete after one wait state");
    chk_maker_code_valid: assert property (st_reg.ph == bay_ctrl_pkg::PH_RDONE && st_reg.ph_idx == bay_ctrl_pkg::IDX_MAKER
                                           |-> o_hrdata == {16'h0000, MAKER_CODE} && o_hrdata[15:0] != 16'hffff)
        else $error("maker code read wrong or all ones");
    chk_revision_read: assert property (st_reg.ph == bay_ctrl_pkg::PH_RDONE && st_reg.ph_idx == bay_ctrl_pkg::IDX_REV
                                        |-> o_hrdata == {24'h000000, REVISION})
        else $error("revision read wrong");
    chk_cap_baycount: assert property (st_reg.ph == bay_ctrl_pkg::PH_RDONE && st_reg.ph_idx == bay_ctrl_pkg::IDX_CAP
                                       |-> o_hrdata[3:0] == 4'(NB) && o_hrdata[31:12] == 20'h00000)
        else $error("capability word wrong");
    chk_unmapped_zero: assert property (st_reg.ph == bay_ctrl_pkg::PH_RDONE && st_reg.ph_idx == 10'h3ff |-> o_hrdata == 32'h0)
        else $error("unmapped index reads nonzero");
    chk_set_beats_clear: assert property (i_ce && irq_set[0] && irq_clr[0] |=> st_reg.irq_sts[0])
        else $error("event lost to simultaneous clear");
    chk_irq_level: assert property (i_ce |=> o_irq == |($past(st_reg.irq_sts) & $past(st_reg.irq_en)))
        else $error("interrupt output mismatch");
endmodule // bay_controller

// ---- inc/bay_ctrl_pkg.sv ----
// package: register indices, field positions, timing and state types of the bay controller
package bay_ctrl_pkg;
    localparam int NUM_BAYS = 2;

    // printed register indices; byte address is four times the index
    localparam logic [9:0] IDX_MAKER      = 10'h000;
    localparam logic [9:0] IDX_REV        = 10'h004;
    localparam logic [9:0] IDX_SUBMAKER   = 10'h008;
    localparam logic [9:0] IDX_SUBCODE    = 10'h00a;
    localparam logic [9:0] IDX_CAP        = 10'h00c;
    localparam logic [9:0] IDX_BAY_STAT   = 10'h010;
    localparam logic [9:0] IDX_BAY_CTRL   = 10'h014;
    localparam logic [9:0] IDX_BAY_STRIDE = 10'h008;
    localparam logic [9:0] IDX_IRQ_STS    = 10'h080;
    localparam logic [9:0] IDX_IRQ_EN     = 10'h081;
    localparam logic [9:0] IDX_IRQ_CLR    = 10'h082;

    // bay control fields
    localparam int CTL_INTERLOCK = 0;
    localparam int CTL_POWER     = 1;
    localparam int CTL_PULSE     = 2;
    // bay status fields
    localparam int STS_REMOVAL   = 0;
    localparam int STS_LOCK      = 7;
    localparam int STS_FF_LSB    = 8;
    // capability fields
    localparam int CAP_BAYCNT_LSB = 0;
    localparam int CAP_SECLOCK    = 4;
    localparam int CAP_DEB_LSB    = 8;

    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    // interlock pulse width
    localparam int CLK_MHZ        = 40;
    localparam int PULSE_NS       = 10000;
    localparam int PULSE_CYC_INT  = (PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam logic [8:0] PULSE_CYC = 9'(PULSE_CYC_INT);

    typedef enum logic [3:0] {
        PH_IDLE  = 4'b0001,
        PH_WRITE = 4'b0010,
        PH_RWAIT = 4'b0100,
        PH_RDONE = 4'b1000
    } phase_t;

    typedef struct packed {
        logic                       hit;
        logic                       is_ctrl;
        logic [0:0]                 bay;
    } bay_dec_t;

    typedef struct packed {
        phase_t                     ph;
        logic [9:0]                 ph_idx;
        logic [31:0]                rdata;
        logic [NUM_BAYS-1:0]        il_ctrl;
        logic [NUM_BAYS-1:0]        pwr_ctrl;
        logic [NUM_BAYS-1:0]        pulse_mode;
        logic [NUM_BAYS-1:0][8:0]   pulse_cnt;
        logic [NUM_BAYS-1:0]        rem_s1;
        logic [NUM_BAYS-1:0]        rem_s2;
        logic [NUM_BAYS-1:0]        lock_s1;
        logic [NUM_BAYS-1:0]        lock_s2;
        logic [NUM_BAYS-1:0]        rem_prev;
        logic [NUM_BAYS-1:0]        lock_prev;
        logic [NUM_BAYS-1:0]        il_out;
        logic [NUM_BAYS-1:0]        pwr_out;
        logic [2*NUM_BAYS-1:0]      irq_sts;
        logic [2*NUM_BAYS-1:0]      irq_en;
        logic                       irq;
    } state_t;
endpackage

// ---- testbench/bay_model.sv ----
// behavioural bay hardware: removal button, key lock, power switch and latch
`timescale 1ns/10ps
module bay_model #(
    parameter logic REM_POL  = 1'b0,
    parameter logic LOCK_POL = 1'b1,
    parameter logic IL_POL   = 1'b1,
    parameter logic PWR_POL  = 1'b1
) (
    input  wire logic [1:0] i_press,
    input  wire logic [1:0] i_engage,
    input  wire logic [1:0] i_interlock,
    input  wire logic [1:0] i_power,
    output logic      [1:0] o_removal_button_in,
    output logic      [1:0] o_physical_lock_sense,
    output logic      [1:0] o_powered,
    output logic      [1:0] o_latched
);
    // button drives its active level only while held
    assign o_removal_button_in   = i_press ^ {2{~REM_POL}};
    // lock sense stands at active level while the key is engaged
    assign o_physical_lock_sense = i_engage ^ {2{~LOCK_POL}};
    // switch conducts and latch holds only at the active level
    assign o_powered = ~(i_power ^ {2{PWR_POL}});
    assign o_latched = ~(i_interlock ^ {2{IL_POL}});
endmodule // bay_model

// ---- testbench/testbench.sv ----
// self-checking bench: ahb-lite registers, bay pins and interrupt
`timescale 1ns/10ps
module testbench;
    localparam logic [15:0] MAKER = 16'h5a17; // arbitrary value
    localparam logic [7:0]  REV   = 8'h23;    // arbitrary value
    localparam logic [15:0] SUBM  = 16'h6e04; // arbitrary value
    localparam logic [15:0] SUBC  = 16'h0102; // arbitrary value
    localparam logic [3:0]  DEB   = 4'h3;
    localparam logic [2:0]  FF    = 3'h2;
    logic        i_clk, i_rst_n, hsel, hwrite, hready, hresp, irq, seen, ce;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd, cnt;
    logic [1:0]  htrans, press, engage, rem, lock, il, pwr, powered, latched;
    logic [9:0]  ci;
    int          n_mismatch, total_checks;

    bay_controller #(.MAKER_CODE(MAKER), .REVISION(REV), .SUBMAKER_CODE(SUBM), .SUB_CODE(SUBC),
        .DEB_TIME(DEB), .SECLOCK_FIT(1'b1), .FORM_FACTOR(FF), .IL_POL(1'b1), .PWR_POL(1'b1),
        .REM_POL(1'b0), .LOCK_POL(1'b1)) dut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
        .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_removal_button_in(rem), .i_physical_lock_sense(lock), .o_interlock(il),
        .o_bay_power_switch_out(pwr), .o_irq(irq));
    bay_model bay (.i_press(press), .i_engage(engage), .i_interlock(il), .i_power(pwr),
        .o_removal_button_in(rem), .o_physical_lock_sense(lock), .o_powered(powered),
        .o_latched(latched));

    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize();
        if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // hready is looked at before the edge so the bench never races the slave
    task automatic wait_ready();
        int n;
        n = 0;
        @(negedge i_clk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 50) begin
                n_mismatch++;
                summarize();
            end
            @(negedge i_clk);
        end
        rd = hrdata;
        @(posedge i_clk);
    endtask
    // one single word transfer; entered just after a rising edge
    task automatic bus(input logic wr, input logic [9:0] idx, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {20'h0, idx, 2'b00};
        wait_ready();
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        wait_ready();
    endtask
    // bounded wait for the interrupt line to reach a level
    task automatic wait_irq(input logic lvl);
        int n;
        for (n = 0; n < 20 && irq !== lvl; n++) @(negedge i_clk);
        if (n >= 20) begin
            n_mismatch++;
            summarize();
        end
        seen = irq;
        @(posedge i_clk);
    endtask
    // write a bay control word and look at the far side once it has settled
    task automatic pin(input int k, input logic [31:0] w, input logic p, input logic l);
        ci = bay_ctrl_pkg::IDX_BAY_CTRL + bay_ctrl_pkg::IDX_BAY_STRIDE * 10'(k);
        bus(1'b1, ci, w);
        repeat (2) @(negedge i_clk);
        check("power", {31'h0, powered[k]}, {31'h0, p});
        check("interlock", {31'h0, latched[k]}, {31'h0, l});
        @(posedge i_clk);
        bus(1'b0, ci, 32'h0);
        check("ctrl readback", rd, w);
    endtask

    task automatic t_ident();
        bus(1'b0, bay_ctrl_pkg::IDX_MAKER, 32'h0);
        check("maker", rd, {16'h0, MAKER});
        check("maker valid", {31'h0, rd === 32'hffff}, 32'h0);
        bus(1'b0, bay_ctrl_pkg::IDX_REV, 32'h0);
        check("revision", rd, {24'h0, REV});
        bus(1'b0, bay_ctrl_pkg::IDX_SUBMAKER, 32'h0);
        check("sub maker", rd, {16'h0, SUBM});
        bus(1'b0, bay_ctrl_pkg::IDX_SUBCODE, 32'h0);
        check("sub code", rd, {16'h0, SUBC});
        bus(1'b0, bay_ctrl_pkg::IDX_CAP, 32'h0);
        check("capability", rd, {20'h0, DEB, 8'h12});
        check("response okay", {31'h0, hresp}, 32'h0);
        bus(1'b1, bay_ctrl_pkg::IDX_MAKER, 32'hffff_ffff);
        bus(1'b1, bay_ctrl_pkg::IDX_CAP, 32'hffff_ffff);
        bus(1'b0, bay_ctrl_pkg::IDX_MAKER, 32'h0);
        check("maker after write", rd, {16'h0, MAKER});
        bus(1'b0, bay_ctrl_pkg::IDX_CAP, 32'h0);
        check("cap after write", rd, {20'h0, DEB, 8'h12});
        bus(1'b1, 10'h0c0, 32'hffff_ffff);
        bus(1'b0, 10'h0c0, 32'h0);
        check("unmapped", rd, 32'h0);
    endtask
    // pulse mode: one 1-to-0 change of the control bit gives a fixed-width pulse
    task automatic t_pulse();
        pin(0, 32'h4, 1'b0, 1'b0);
        bus(1'b1, bay_ctrl_pkg::IDX_BAY_CTRL, 32'h5);
        bus(1'b1, bay_ctrl_pkg::IDX_BAY_CTRL, 32'h4);
        cnt = 0;
        repeat (600) begin
            @(negedge i_clk);
            cnt += {31'h0, latched[0]};
        end
        check("pulse width", cnt, 32'(bay_ctrl_pkg::PULSE_CYC_INT));
        @(posedge i_clk);
    endtask
    // removal and lock events: sticky status, mask, clear
    task automatic t_events();
        bus(1'b1, bay_ctrl_pkg::IDX_IRQ_EN, 32'hf);
        press <= 2'b01;
        wait_irq(1'b1);
        check("irq raised", {31'h0, seen}, 32'h1);
        bus(1'b0, bay_ctrl_pkg::IDX_BAY_STAT, 32'h0);
        check("bay0 status", rd, {21'h0, FF, 8'h01});
        press <= 2'b00;
        bus(1'b1, bay_ctrl_pkg::IDX_IRQ_EN, 32'h0);
        wait_irq(1'b0);
        check("irq masked", {31'h0, seen}, 32'h0);
        bus(1'b0, bay_ctrl_pkg::IDX_IRQ_STS, 32'h0);
        check("sticky", rd, 32'h1);
        bus(1'b1, bay_ctrl_pkg::IDX_IRQ_CLR, 32'h1);
        bus(1'b1, bay_ctrl_pkg::IDX_IRQ_EN, 32'hf);
        bus(1'b0, bay_ctrl_pkg::IDX_IRQ_STS, 32'h0);
        check("cleared", rd, 32'h0);
        check("irq quiet", {31'h0, irq}, 32'h0);
        engage <= 2'b10;
        wait_irq(1'b1);
        bus(1'b0, bay_ctrl_pkg::IDX_IRQ_STS, 32'h0);
        check("lock event", rd, 32'h8);
        bus(1'b0, bay_ctrl_pkg::IDX_BAY_STAT + bay_ctrl_pkg::IDX_BAY_STRIDE, 32'h0);
        check("bay1 status", rd, {21'h0, FF, 8'h80});
        bus(1'b1, bay_ctrl_pkg::IDX_IRQ_CLR, 32'h8);
        wait_irq(1'b0);
        check("irq cleared", {31'h0, seen}, 32'h0);
    endtask

    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    initial begin
        {i_rst_n, hsel, hwrite, htrans, haddr, hwdata, press, engage} = '0;
        ce = 1'b1;
        hsize = 3'h2;
        n_mismatch = 0;
        total_checks = 0;
        repeat (4) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        check("reset power", {30'h0, powered}, 32'h0);
        bus(1'b0, bay_ctrl_pkg::IDX_BAY_CTRL, 32'h0);
        check("reset ctrl", rd, 32'h0);
        t_ident();
        pin(0, 32'h2, 1'b1, 1'b0);
        pin(1, 32'h1, 1'b0, 1'b1);
        pin(1, 32'h3, 1'b1, 1'b1);
        pin(0, 32'h0, 1'b0, 1'b0);
        t_pulse();
        t_events();
        summarize();
    end
endmodule // testbench
